// >>> fpu_memory_transfer_port.sv
/*
 * Data-transfer side of the floating point coprocessor, with its word FIFO.
 * Assumes all inputs synchronous to mclk_i; the bus clock is a sampled level.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fpu_xfer_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module xfer_word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic push, pop;

	// Count is one bit wider than the pointers so that full and empty differ
	assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_ff != '0);
	assign out_data_o = mem_ff[rp_ff];

	always_comb begin
		push = in_valid_i & in_ready_o;
		pop = out_valid_o & out_ready_i;
		nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
		nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
		nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wp_ff <= nxt_wp;
			rp_ff <= nxt_rp;
			cnt_ff <= nxt_cnt;
		end
	end

	// Storage needs no reset; only the pointers define content
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_ff[wp_ff] <= in_data_i;
		end
	end
endmodule : xfer_word_fifo

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Words move only in the data phase of a flagged memory cycle.
// - Data phase: memory cycle drives input bus on store, captures output bus on load; host cycle the reverse.
// - Single operand takes two cycles, double takes four.
// - Loaded words accumulate one per cycle in the working register.
// - First word goes to exponent file, later words to mantissa unit.
// - Finished operation result lands in the floating accumulator.
// - Store sends sign/exponent word first, then mantissa words one per cycle.
// - Timing from 40 MHz clock, derived 20/10 MHz enables, sampled bus clock.
// - Buses are sixteen bits with bit 0 most significant.
// - Instruction strobe latches instruction bits into instruction register.
// - Busy held low while executing, released high when done.
// - Latched instruction is decoded only after busy has been released.
module fpu_memory_transfer_port #(
	parameter int FIFO_DEPTH = `FXP_FIFO_DEPTH
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic memory_bus_clock_i,
	input wire logic memory_cycle_start_n_i,
	input wire logic coproc_memory_xfer_n_i,
	input wire logic coproc_host_xfer_n_i,
	input wire logic memory_inhibit_n_i,
	input wire logic coproc_instruction_strobe_n_i,
	input wire logic [`FXP_INSN_W-1:0] insn_bits_i,
	input wire logic [0:`FXP_WORD_W-1] memory_input_bus_i,
	input wire logic [0:`FXP_WORD_W-1] memory_output_bus_i,
	output logic [0:`FXP_WORD_W-1] memory_input_bus_o,
	output logic memory_input_bus_oe_o,
	output logic [0:`FXP_WORD_W-1] memory_output_bus_o,
	output logic memory_output_bus_oe_o,
	output logic coproc_busy_n_o,
	output logic [`FXP_INSN_W-1:0] coproc_instruction_register_o,
	output logic exp_wr_o,
	output logic mant_wr_o,
	output logic [0:`FXP_WORD_W-1] xfer_word_o,
	output logic [0:`FXP_OPND_W-1] floating_accumulator_o
);
	fpu_xfer_pkg::op_state_t st_ff, nxt_st;
	fpu_xfer_pkg::bus_phase_t ph_ff, nxt_ph;
	logic [1:0] div_ff, nxt_div;
	logic tick_mid, tick_slow;
	logic start_d_ff, bclk_d_ff, strb_d_ff;
	logic pend_ff, nxt_pend, dbl_ff, nxt_dbl, host_ff, nxt_host;
	logic [`FXP_INSN_W-1:0] ir_ff, nxt_ir;
	logic [2:0] xcnt_ff, nxt_xcnt, acnt_ff, nxt_acnt, ecnt_ff, nxt_ecnt;
	logic [0:`FXP_OPND_W-1] wr_ff, nxt_wr, acc_ff, nxt_acc;
	logic [0:`FXP_WORD_W-1] word_ff, nxt_word;
	logic ewr_ff, nxt_ewr, mwr_ff, nxt_mwr;
	logic [0:`FXP_WORD_W-1] in_o_ff, nxt_in_o, out_o_ff, nxt_out_o;
	logic in_oe_ff, nxt_in_oe, out_oe_ff, nxt_out_oe;
	logic [2:0] total;
	logic flagged, start_fall, bclk_rise, data_end;
	logic cap_valid, cap_ready, q_valid, q_ready;
	logic [0:`FXP_WORD_W-1] cap_data, q_data;

	////////////////////////////////////////////////////////////////////////
	// Rate enables
	always_comb begin
		nxt_div = div_ff + 2'h1;
		tick_mid = div_ff[0];
		tick_slow = (div_ff == 2'(`FXP_SLOW_DIV - 1));
	end

	xfer_word_fifo #(.WIDTH(`FXP_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(cap_valid),
		.in_ready_o(cap_ready),
		.in_data_i(cap_data),
		.out_valid_o(q_valid),
		.out_ready_i(q_ready),
		.out_data_o(q_data)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		total = dbl_ff ? `FXP_DBL_WORDS : `FXP_SGL_WORDS;
		start_fall = start_d_ff & ~memory_cycle_start_n_i;
		flagged = ~coproc_memory_xfer_n_i | (~coproc_host_xfer_n_i & ~memory_inhibit_n_i);
		bclk_rise = ~bclk_d_ff & memory_bus_clock_i;
		data_end = (ph_ff == fpu_xfer_pkg::PH_DATA) & bclk_rise;
		nxt_ph = ph_ff;
		nxt_host = host_ff;
		case (ph_ff)
			fpu_xfer_pkg::PH_IDLE: begin
				if (start_fall && flagged && xcnt_ff < total &&
						(st_ff == fpu_xfer_pkg::OP_LOAD || st_ff == fpu_xfer_pkg::OP_STORE)) begin
					nxt_ph = fpu_xfer_pkg::PH_ADDR;
					nxt_host = coproc_memory_xfer_n_i;
				end
			end
			fpu_xfer_pkg::PH_ADDR: begin
				if (bclk_rise) begin
					nxt_ph = fpu_xfer_pkg::PH_DATA;
				end
			end
			fpu_xfer_pkg::PH_DATA: begin
				if (bclk_rise) begin
					nxt_ph = fpu_xfer_pkg::PH_IDLE;
				end
			end
			default: nxt_ph = fpu_xfer_pkg::PH_IDLE;
		endcase
		// Capture at data phase end; a full buffer drops the word
		cap_valid = data_end & (st_ff == fpu_xfer_pkg::OP_LOAD);
		cap_data = host_ff ? memory_input_bus_i : memory_output_bus_i;
		// Draining paced at 20 MHz keeps the buffer honest under load
		q_ready = (st_ff == fpu_xfer_pkg::OP_LOAD) & tick_mid;
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_st = st_ff;
		nxt_pend = pend_ff;
		nxt_ir = ir_ff;
		nxt_dbl = dbl_ff;
		nxt_xcnt = xcnt_ff;
		nxt_acnt = acnt_ff;
		nxt_ecnt = ecnt_ff;
		nxt_wr = wr_ff;
		nxt_acc = acc_ff;
		nxt_word = word_ff;
		nxt_ewr = 1'b0;
		nxt_mwr = 1'b0;
		if (data_end && (st_ff == fpu_xfer_pkg::OP_STORE || cap_ready)) begin
			nxt_xcnt = xcnt_ff + 3'h1;
		end
		case (st_ff)
			fpu_xfer_pkg::OP_IDLE: begin
				if (pend_ff) begin
					nxt_pend = 1'b0;
					nxt_dbl = ir_ff[`FXP_INSN_DBL_BIT];
					nxt_xcnt = 3'h0;
					nxt_acnt = 3'h0;
					nxt_wr = acc_ff;
					nxt_st = ir_ff[`FXP_INSN_STORE_BIT] ? fpu_xfer_pkg::OP_STORE :
						fpu_xfer_pkg::OP_LOAD;
				end
			end
			fpu_xfer_pkg::OP_LOAD: begin
				if (q_valid && q_ready) begin
					nxt_wr = {wr_ff[`FXP_WORD_W:`FXP_OPND_W-1], q_data};
					nxt_word = q_data;
					nxt_ewr = (acnt_ff == 3'h0);
					nxt_mwr = (acnt_ff != 3'h0);
					nxt_acnt = acnt_ff + 3'h1;
					if (acnt_ff + 3'h1 == total) begin
						nxt_ecnt = 3'h0;
						nxt_st = fpu_xfer_pkg::OP_EXEC;
					end
				end
			end
			fpu_xfer_pkg::OP_EXEC: begin
				if (tick_slow) begin
					nxt_ecnt = ecnt_ff + 3'h1;
				end
				if (ecnt_ff == `FXP_EXEC_TICKS) begin
					nxt_acc = dbl_ff ? wr_ff :
						{wr_ff[`FXP_OPND_W/2:`FXP_OPND_W-1], {(`FXP_OPND_W/2){1'b0}}};
					nxt_st = fpu_xfer_pkg::OP_IDLE;
				end
			end
			fpu_xfer_pkg::OP_STORE: begin
				// Exponent word first, then mantissa words
				if (data_end) begin
					nxt_wr = {wr_ff[`FXP_WORD_W:`FXP_OPND_W-1], {`FXP_WORD_W{1'b0}}};
					if (xcnt_ff + 3'h1 == total) begin
						nxt_st = fpu_xfer_pkg::OP_IDLE;
					end
				end
			end
			default: nxt_st = fpu_xfer_pkg::OP_IDLE;
		endcase
		// Strobe latches instruction; a new strobe wins over decode
		if (strb_d_ff && !coproc_instruction_strobe_n_i) begin
			nxt_ir = insn_bits_i;
			nxt_pend = 1'b1;
		end
		// Drive only in data phase of own store cycle
		nxt_in_oe = (nxt_ph == fpu_xfer_pkg::PH_DATA) & (st_ff == fpu_xfer_pkg::OP_STORE) &
			~nxt_host;
		nxt_out_oe = (nxt_ph == fpu_xfer_pkg::PH_DATA) & (st_ff == fpu_xfer_pkg::OP_STORE) &
			nxt_host;
		// Word zero of operand is bits 0..15
		nxt_in_o = nxt_in_oe ? wr_ff[0:`FXP_WORD_W-1] : '0;
		nxt_out_o = nxt_out_oe ? wr_ff[0:`FXP_WORD_W-1] : '0;
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_ff <= fpu_xfer_pkg::OP_IDLE;
			ph_ff <= fpu_xfer_pkg::PH_IDLE;
			div_ff <= 2'h0;
			start_d_ff <= 1'b1;
			bclk_d_ff <= 1'b0;
			strb_d_ff <= 1'b1;
			pend_ff <= 1'b0;
			dbl_ff <= 1'b0;
			host_ff <= 1'b0;
			ir_ff <= '0;
			xcnt_ff <= 3'h0;
			acnt_ff <= 3'h0;
			ecnt_ff <= 3'h0;
			wr_ff <= '0;
			acc_ff <= '0;
			word_ff <= '0;
			ewr_ff <= 1'b0;
			mwr_ff <= 1'b0;
			in_o_ff <= '0;
			out_o_ff <= '0;
			in_oe_ff <= 1'b0;
			out_oe_ff <= 1'b0;
			coproc_busy_n_o <= 1'b1;
		end else begin
			st_ff <= nxt_st;
			ph_ff <= nxt_ph;
			div_ff <= nxt_div;
			start_d_ff <= memory_cycle_start_n_i;
			bclk_d_ff <= memory_bus_clock_i;
			strb_d_ff <= coproc_instruction_strobe_n_i;
			pend_ff <= nxt_pend;
			dbl_ff <= nxt_dbl;
			host_ff <= nxt_host;
			ir_ff <= nxt_ir;
			xcnt_ff <= nxt_xcnt;
			acnt_ff <= nxt_acnt;
			ecnt_ff <= nxt_ecnt;
			wr_ff <= nxt_wr;
			acc_ff <= nxt_acc;
			word_ff <= nxt_word;
			ewr_ff <= nxt_ewr;
			mwr_ff <= nxt_mwr;
			in_o_ff <= nxt_in_o;
			out_o_ff <= nxt_out_o;
			in_oe_ff <= nxt_in_oe;
			out_oe_ff <= nxt_out_oe;
			coproc_busy_n_o <= (nxt_st != fpu_xfer_pkg::OP_EXEC);
		end
	end

	assign memory_input_bus_o = in_o_ff;
	assign memory_input_bus_oe_o = in_oe_ff;
	assign memory_output_bus_o = out_o_ff;
	assign memory_output_bus_oe_o = out_oe_ff;
	assign coproc_instruction_register_o = ir_ff;
	assign exp_wr_o = ewr_ff;
	assign mant_wr_o = mwr_ff;
	assign xfer_word_o = word_ff;
	assign floating_accumulator_o = acc_ff;

	////////////////////////////////////////////////////////////////////////
	sequence s_strobe_fall;
		strb_d_ff && !coproc_instruction_strobe_n_i;
	endsequence
	sequence s_load_done;
		st_ff == fpu_xfer_pkg::OP_EXEC && ecnt_ff == `FXP_EXEC_TICKS;
	endsequence

	property p_drive_data_only;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(in_oe_ff || out_oe_ff) |-> ph_ff == fpu_xfer_pkg::PH_DATA;
	endproperty
	a_drive_data_only: assert property (p_drive_data_only) else $error("bus driven outside data");

	property p_one_drive;
		@(posedge mclk_i) disable iff (!rst_b_i)
		!(in_oe_ff && out_oe_ff);
	endproperty
	a_one_drive: assert property (p_one_drive) else $error("both buses driven");

	property p_store_word;
		@(posedge mclk_i) disable iff (!rst_b_i)
		in_oe_ff |-> memory_input_bus_o == wr_ff[0:`FXP_WORD_W-1];
	endproperty
	a_store_word: assert property (p_store_word) else $error("wrong store word");

	property p_word_limit;
		@(posedge mclk_i) disable iff (!rst_b_i)
		xcnt_ff <= total;
	endproperty
	a_word_limit: assert property (p_word_limit) else $error("too many words");

	property p_latch;
		@(posedge mclk_i) disable iff (!rst_b_i)
		s_strobe_fall |=> ir_ff == $past(insn_bits_i) && pend_ff;
	endproperty
	a_latch: assert property (p_latch) else $error("instruction not latched");

	property p_busy;
		@(posedge mclk_i) disable iff (!rst_b_i)
		st_ff == fpu_xfer_pkg::OP_EXEC |-> !coproc_busy_n_o;
	endproperty
	a_busy: assert property (p_busy) else $error("busy not shown");

	property p_no_decode_busy;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(!coproc_busy_n_o && pend_ff) |=> st_ff != fpu_xfer_pkg::OP_LOAD &&
			st_ff != fpu_xfer_pkg::OP_STORE;
	endproperty
	a_no_decode_busy: assert property (p_no_decode_busy) else $error("decoded while busy");

	property p_result;
		@(posedge mclk_i) disable iff (!rst_b_i)
		s_load_done ##1 1'b1 |-> st_ff == fpu_xfer_pkg::OP_IDLE && coproc_busy_n_o;
	endproperty
	a_result: assert property (p_result) else $error("result not finished");

	property p_first_exp;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(st_ff == fpu_xfer_pkg::OP_LOAD && q_valid && q_ready && acnt_ff == 3'h0) |=>
			exp_wr_o && !mant_wr_o && xfer_word_o == $past(q_data);
	endproperty
	a_first_exp: assert property (p_first_exp) else $error("first word misrouted");
endmodule : fpu_memory_transfer_port
`default_nettype wire

// >>> fpu_xfer_defines.svh
/*
 * Constants of the coprocessor transfer port: clock rates, word counts,
 * instruction fields and buffer sizes.
 * Assumes inclusion by its bare name from the design file.
 */
`ifndef FPU_XFER_DEFINES_SVH
`define FPU_XFER_DEFINES_SVH

`define FXP_CLK_MHZ 40
`define FXP_MID_MHZ 20
`define FXP_SLOW_MHZ 10
`define FXP_MID_DIV (`FXP_CLK_MHZ / `FXP_MID_MHZ)
`define FXP_SLOW_DIV (`FXP_CLK_MHZ / `FXP_SLOW_MHZ)
`define FXP_WORD_W 16
`define FXP_OPND_W 64
`define FXP_INSN_W 9
`define FXP_INSN_STORE_BIT 0
`define FXP_INSN_DBL_BIT 1
`define FXP_SGL_WORDS 3'h2
`define FXP_DBL_WORDS 3'h4
`define FXP_EXEC_TICKS 3'h4
`define FXP_FIFO_DEPTH 16

`endif

// >>> fpu_xfer_pkg.sv
/*
 * Types of the coprocessor transfer port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fpu_xfer_pkg;
	typedef enum logic [2:0] {
		OP_IDLE = 3'b000,
		OP_LOAD = 3'b001,
		OP_EXEC = 3'b010,
		OP_STORE = 3'b011
	} op_state_t;
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_ADDR = 2'b01,
		PH_DATA = 2'b10
	} bus_phase_t;
endpackage : fpu_xfer_pkg

// >>> fpu_host_model.sv
/*
 * Host CPU and memory model: bus clock and memory cycles on both buses.
 * Assumes the bench resolves the shared buses from every enable.
 */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module host_bus_model (
	input wire logic mclk_i,
	output logic memory_bus_clock_o,
	output logic memory_cycle_start_n_o,
	output logic coproc_memory_xfer_n_o,
	output logic coproc_host_xfer_n_o,
	output logic memory_inhibit_n_o,
	output logic [0:15] host_in_bus_o,
	output logic [0:15] mem_out_bus_o,
	input wire logic [0:15] in_wire_i,
	input wire logic [0:15] out_wire_i,
	output logic drv_mem_ok_o,
	output logic drv_host_ok_o
);
	int unsigned tick = 0;
	initial begin
		memory_bus_clock_o = 1'h0;
		memory_cycle_start_n_o = 1'h1;
		coproc_memory_xfer_n_o = 1'h1;
		coproc_host_xfer_n_o = 1'h1;
		memory_inhibit_n_o = 1'h1;
		host_in_bus_o = 16'h0000;
		mem_out_bus_o = 16'hFFFF;
		drv_mem_ok_o = 1'h0;
		drv_host_ok_o = 1'h0;
	end
	always @(negedge mclk_i) begin
		tick <= tick + 1;
		if (tick % 2 == 1) memory_bus_clock_o <= ~memory_bus_clock_o;
	end
	task automatic run_cycle(input bit host, input bit load, input int gap,
		input logic [0:15] wr, output logic [0:15] rd);
		repeat (gap) @(posedge memory_bus_clock_o);
		@(negedge memory_bus_clock_o);
		memory_cycle_start_n_o = 1'h0;
		coproc_memory_xfer_n_o = host;
		coproc_host_xfer_n_o = !host;
		memory_inhibit_n_o = !host;
		host_in_bus_o = 16'(tick);
		@(posedge memory_bus_clock_o);
		host_in_bus_o = (load && host) ? wr : ~host_in_bus_o;
		mem_out_bus_o = (load && !host) ? wr : ~mem_out_bus_o;
		drv_mem_ok_o = !load && !host;
		drv_host_ok_o = !load && host;
		@(posedge memory_bus_clock_o);
		rd = host ? out_wire_i : in_wire_i;
		@(posedge mclk_i);
		@(negedge mclk_i);
		// Released lines toggle so stale data never looks valid
		memory_cycle_start_n_o = 1'h1;
		coproc_memory_xfer_n_o = 1'h1;
		coproc_host_xfer_n_o = 1'h1;
		memory_inhibit_n_o = 1'h1;
		host_in_bus_o = ~host_in_bus_o;
		mem_out_bus_o = ~mem_out_bus_o;
		@(negedge mclk_i);
		drv_mem_ok_o = 1'h0;
		drv_host_ok_o = 1'h0;
	endtask : run_cycle
endmodule : host_bus_model
`default_nettype wire

// >>> tb.sv
/*
 * Bench: loads and stores of both sizes over memory and host paths.
 * Assumes the host model and the design are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module tb;
	logic mclk = 1'h0;
	logic rst_b = 1'h0;
	logic strobe_n = 1'h1;
	logic [8:0] insn = 9'h000;
	logic [8:0] ir;
	logic bclk, start_n, mem_n, host_n, inh_n, ok_m, ok_h;
	logic oe_in, oe_out, busy_n, ew, mw;
	logic [0:15] h_in, m_out, w_in, w_out, d_in, d_out, xw;
	logic [0:63] acc;
	logic [0:63] acc_x = 64'h0;
	logic [16:0] wq[$];
	int mismatches = 0;
	int n_tests = 0;
	int seed = 81;
	assign w_in = oe_in ? d_in : h_in;
	assign w_out = oe_out ? d_out : m_out;
	always #12.5 mclk = ~mclk;

	host_bus_model hm (.mclk_i(mclk), .memory_bus_clock_o(bclk),
		.memory_cycle_start_n_o(start_n), .coproc_memory_xfer_n_o(mem_n),
		.coproc_host_xfer_n_o(host_n), .memory_inhibit_n_o(inh_n),
		.host_in_bus_o(h_in), .mem_out_bus_o(m_out), .in_wire_i(w_in),
		.out_wire_i(w_out), .drv_mem_ok_o(ok_m), .drv_host_ok_o(ok_h));

	fpu_memory_transfer_port #(.FIFO_DEPTH(16)) DUT (.mclk_i(mclk), .rst_b_i(rst_b),
		.memory_bus_clock_i(bclk), .memory_cycle_start_n_i(start_n),
		.coproc_memory_xfer_n_i(mem_n), .coproc_host_xfer_n_i(host_n),
		.memory_inhibit_n_i(inh_n), .coproc_instruction_strobe_n_i(strobe_n),
		.insn_bits_i(insn), .memory_input_bus_i(w_in), .memory_output_bus_i(w_out),
		.memory_input_bus_o(d_in), .memory_input_bus_oe_o(oe_in),
		.memory_output_bus_o(d_out), .memory_output_bus_oe_o(oe_out),
		.coproc_busy_n_o(busy_n), .coproc_instruction_register_o(ir),
		.exp_wr_o(ew), .mant_wr_o(mw), .xfer_word_o(xw), .floating_accumulator_o(acc));

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict;
		$display("checks=%0d mismatches=%0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict

	always @(posedge mclk) if (ew || mw) begin
		logic [16:0] e;
		if (wq.size() == 0) begin
			check(1, 0);
		end else begin
			e = wq.pop_front();
			check({ew, mw, xw}, {e[16], !e[16], e[15:0]});
		end
	end
	always @(posedge mclk) if (rst_b) begin
		if (oe_in && !ok_m) check(oe_in, 0);
		if (oe_out && !ok_h) check(oe_out, 0);
	end

	task automatic issue(input logic [8:0] b);
		@(negedge mclk);
		insn = b;
		strobe_n = 1'h0;
		@(negedge mclk);
		strobe_n = 1'h1;
		@(negedge mclk);
		check(ir, b);
	endtask : issue

	task automatic wait_busy(input logic lvl);
		int k;
		k = 0;
		while (busy_n !== lvl && k < 200) begin
			@(negedge mclk);
			k++;
		end
		check(busy_n, lvl);
	endtask : wait_busy

	task automatic xfer(input bit host, input bit store, input bit dbl);
		logic [0:15] w, r;
		for (int i = 0; i < (dbl ? 4 : 2); i++) begin
			w = 16'($random(seed));
			if (!store) begin
				wq.push_back({i == 0, w});
				acc_x[16*i +: 16] = w;
			end
			hm.run_cycle(host, !store, int'(w[0]), w, r);
			if (store) check(r, acc_x[16*i +: 16]);
		end
	endtask : xfer

	initial begin
		logic [0:15] r;
		repeat (20) @(negedge mclk);
		rst_b = 1'h1;
		repeat (2) @(negedge mclk);
		check(busy_n, 1);
		hm.run_cycle(0, 1, 0, 16'hA5A5, r);
		for (int i = 0; i < 4; i++) begin
			acc_x = 64'h0;
			issue({7'h00, i[1], 1'h0});
			repeat (3) @(negedge mclk);
			xfer(i[0], 0, i[1]);
			wait_busy(0);
			// Store strobed while busy stays pending
			issue({7'h00, i[1], 1'h1});
			wait_busy(1);
			check(acc, acc_x);
			check(wq.size(), 0);
			repeat (3) @(negedge mclk);
			xfer(!i[0], 1, i[1]);
		end
		give_verdict();
	end

	// Far beyond the expected run of a few hundred cycles
	initial begin
		#1000000;
		mismatches++;
		give_verdict();
	end
endmodule : tb
`default_nettype wire
